// [src/ohpfs_map.svh]
// constants of the oled host port and frame store
`ifndef OHPFS_MAP_SVH
`define OHPFS_MAP_SVH
// ***********************************
// straps {2,1,0}
// ***********************************
`define OHPFS_STRAP_PAR 3'h6
`define OHPFS_STRAP_SPI 3'h0
`define OHPFS_STRAP_I2C 3'h2
// ***********************************
// commands
// ***********************************
`define OHPFS_CMD_OFF 8'hae
`define OHPFS_CMD_ON 8'haf
`define OHPFS_CMD_CONTRAST 8'hc1
`define OHPFS_CMD_REMAP 8'ha0
`define OHPFS_CMD_PAGE 8'hb0
`define OHPFS_CMD_PAGE_MASK 8'hf8
`define OHPFS_CMD_COL_LO 8'h00
`define OHPFS_CMD_COL_LO_MASK 8'hf0
`define OHPFS_CMD_COL_HI 8'h10
`define OHPFS_CMD_COL_HI_MASK 8'hf8
`define OHPFS_REMAP_COL_BIT 0
`define OHPFS_REMAP_ROW_BIT 1
`define OHPFS_I2C_CTRL_DC_BIT 6
`define OHPFS_STAT_ON_BIT 6
// ***********************************
// reset values and timing
// ***********************************
`define OHPFS_CONTRAST_RST 8'h80
`define OHPFS_I2C_ADDR 7'h3c
`define OHPFS_LAST_COL 7'h7f
`define OHPFS_ON_DELAY_MS 200
`define OHPFS_CLK_HZ 10000000
`endif

// [src/ohpfs_pkg.sv]
// types of the oled host port and frame store
`default_nettype none
package ohpfs_pkg;
  typedef enum logic [1:0] {M_PAR, M_SPI, M_I2C} ohpfs_mode_e;
  typedef enum logic [2:0] {C_IDLE, C_CA, C_CB, C_CC, C_REMAP} ohpfs_cmd_e;
  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_CTRL, I_DATA} ohpfs_i2c_e;
endpackage
`default_nettype wire

// [src/ohpfs_top.sv]
// host port, command decoder and frame store of the oled module
`timescale 1ns/100ps
`default_nettype none
`include "ohpfs_map.svh"
// Contract
// [R1] straps 110 parallel, 000 serial select port
// [R2] serial mode: bit0 clock, bit1 data
// [R3] i2c: bit0 clock, bits 2/1 data
// [R4] host ties unused data pins low
// [R5] parallel bus driven out on reads
// [R6] data/command low command, high data
// [R7] chip select high: bus ignored
// [R8] host signals read or write per transfer
// [R9] clear input restores default state
// [R10] store 128 columns by 8 pages
// [R11] data byte fills whole page column
// [R12] bit 0 top row, bit 7 bottom
// [R13] 0xae: display off, store kept
// [R14] 0xaf: display on, store shown
// [R15] 0xc1 then contrast a, b, c
// [R16] host holds clear at least 3 us
// [R17] host waits 300 ms before commands
// [R18] drive enabled within 200 ms of on
// [R19] host sends off before power removal
// [R20] row and column remap reverse lines
// [R21] parallel byte taken at write trailing edge
// [R22] column pointer advances per data byte
module ohpfs_top #(
  parameter int ON_DELAY_CYC = `OHPFS_ON_DELAY_MS * (`OHPFS_CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic module_clear_n,
  input wire logic host_port_strap_0,
  input wire logic host_port_strap_1,
  input wire logic host_port_strap_2,
  input wire logic chip_select_n,
  input wire logic data_cmd_sel,
  input wire logic host_write_n,
  input wire logic host_read_n,
  input wire logic [7:0] data_in,
  input wire logic [6:0] scan_col,
  input wire logic [5:0] scan_row,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  output logic display_on,
  output logic panel_drive_en,
  output logic [7:0] contrast_a,
  output logic [7:0] contrast_b,
  output logic [7:0] contrast_c,
  output logic pixel_out
);
  // ***********************************
  // helpers
  // ***********************************
  function automatic logic [9:0] fs_index(input logic [2:0] pg, input logic [6:0] cl);
    fs_index = {pg, cl};
  endfunction

  function automatic logic cmd_hit(input logic [7:0] b, input logic [7:0] m,
                                   input logic [7:0] v);
    cmd_hit = ((b & m) == v);
  endfunction

  // ***********************************
  // pin synchronisers
  // ***********************************
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  logic [1:0] d_s3;
  logic wr_n_s3;
  wire logic [15:0] pin_raw = {module_clear_n, host_port_strap_2, host_port_strap_1,
                               host_port_strap_0, chip_select_n, data_cmd_sel,
                               host_write_n, host_read_n, data_in};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 16'hff00;
      pin_s2 <= 16'hff00;
      d_s3 <= 2'h0;
      wr_n_s3 <= 1'b1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      d_s3 <= pin_s2[1:0];
      wr_n_s3 <= pin_s2[9];
    end
  end

  wire logic clr = !pin_s2[15];
  wire logic [2:0] strap = pin_s2[14:12];
  wire logic cs_q = !pin_s2[11];
  wire logic dc_q = pin_s2[10];
  wire logic wr_n_q = pin_s2[9];
  wire logic rd_n_q = pin_s2[8];
  wire logic [7:0] d_q = pin_s2[7:0];

  // ***********************************
  // mode straps
  // ***********************************
  // straps are sampled on every boot count and during clear; the last boot sample, at count 2, sees real pin levels
  ohpfs_pkg::ohpfs_mode_e mode;
  logic [1:0] boot;
  wire logic live = (boot == 2'h3) && !clr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot <= 2'h0;
      mode <= ohpfs_pkg::M_I2C;
    end else if (clr || boot != 2'h3) begin
      if (boot != 2'h3) boot <= boot + 2'h1;
      case (strap) // R1
        `OHPFS_STRAP_PAR: mode <= ohpfs_pkg::M_PAR;
        `OHPFS_STRAP_SPI: mode <= ohpfs_pkg::M_SPI;
        default: mode <= ohpfs_pkg::M_I2C;
      endcase
    end
  end

  // ***********************************
  // parallel and serial capture
  // ***********************************
  wire logic par_on = live && mode == ohpfs_pkg::M_PAR && cs_q;
  wire logic par_stb = par_on && wr_n_q && !wr_n_s3; // R21 R7 R8
  wire logic sclk_rise = d_q[0] && !d_s3[0]; // R2
  logic [2:0] spi_cnt;
  logic [6:0] spi_sh;
  wire logic spi_on = live && mode == ohpfs_pkg::M_SPI && cs_q; // R7
  wire logic spi_stb = spi_on && sclk_rise && spi_cnt == 3'h7;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_cnt <= 3'h0;
      spi_sh <= 7'h00;
    end else if (!spi_on) begin
      spi_cnt <= 3'h0; // deselect realigns the byte boundary
    end else if (sclk_rise) begin
      spi_sh <= {spi_sh[5:0], d_q[1]}; // R2
      spi_cnt <= spi_cnt + 3'h1;
    end
  end

  // ***********************************
  // i2c slave
  // ***********************************
  ohpfs_pkg::ohpfs_i2c_e i2c_st;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_sh;
  logic i2c_ack;
  logic i2c_dc;
  wire logic scl_rise = d_q[0] && !d_s3[0];
  wire logic scl_fall = !d_q[0] && d_s3[0];
  wire logic scl_hi = d_q[0] && d_s3[0];
  wire logic i2c_start = scl_hi && d_s3[1] && !d_q[1]; // R3
  wire logic i2c_stop = scl_hi && !d_s3[1] && d_q[1];
  wire logic i2c_on = live && mode == ohpfs_pkg::M_I2C && cs_q; // R7
  wire logic i2c_stb = i2c_on && !i2c_start && !i2c_stop && scl_fall && !i2c_ack
                       && i2c_cnt == 4'h8 && i2c_st == ohpfs_pkg::I_DATA;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_st <= ohpfs_pkg::I_IDLE;
      i2c_cnt <= 4'h0;
      i2c_sh <= 8'h00;
      i2c_ack <= 1'b0;
      i2c_dc <= 1'b0;
    end else if (!i2c_on || i2c_stop) begin
      i2c_st <= ohpfs_pkg::I_IDLE;
      i2c_ack <= 1'b0;
      i2c_cnt <= 4'h0;
    end else if (i2c_start) begin
      i2c_st <= ohpfs_pkg::I_ADDR;
      i2c_ack <= 1'b0;
      i2c_cnt <= 4'h0;
    end else if (scl_rise && !i2c_ack && i2c_st != ohpfs_pkg::I_IDLE) begin
      i2c_sh <= {i2c_sh[6:0], d_q[1]};
      i2c_cnt <= i2c_cnt + 4'h1;
    end else if (scl_fall && i2c_ack) begin
      i2c_ack <= 1'b0;
    end else if (scl_fall && i2c_cnt == 4'h8) begin
      i2c_cnt <= 4'h0;
      case (i2c_st)
        ohpfs_pkg::I_ADDR: begin
          if (i2c_sh[7:1] == `OHPFS_I2C_ADDR && !i2c_sh[0]) begin
            i2c_ack <= 1'b1;
            i2c_st <= ohpfs_pkg::I_CTRL;
          end else begin
            i2c_st <= ohpfs_pkg::I_IDLE;
          end
        end
        ohpfs_pkg::I_CTRL: begin
          i2c_ack <= 1'b1;
          i2c_dc <= i2c_sh[`OHPFS_I2C_CTRL_DC_BIT];
          i2c_st <= ohpfs_pkg::I_DATA;
        end
        ohpfs_pkg::I_DATA: i2c_ack <= 1'b1;
        default: i2c_st <= ohpfs_pkg::I_IDLE;
      endcase
    end
  end

  // ***********************************
  // byte merge
  // ***********************************
  logic byte_stb;
  logic [7:0] byte_val;
  logic byte_dc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_stb <= 1'b0;
      byte_val <= 8'h00;
      byte_dc <= 1'b0;
    end else begin
      byte_stb <= par_stb || spi_stb || i2c_stb;
      if (par_stb) begin
        byte_val <= d_q; // R21
        byte_dc <= dc_q; // R6
      end else if (spi_stb) begin
        byte_val <= {spi_sh, d_q[1]};
        byte_dc <= dc_q; // R6
      end else if (i2c_stb) begin
        byte_val <= i2c_sh;
        byte_dc <= i2c_dc;
      end
    end
  end

  // ***********************************
  // command decoder and pointers
  // ***********************************
  // parameters travel as command bytes; data bytes never disturb a pending parameter
  ohpfs_pkg::ohpfs_cmd_e cmd_st;
  logic [6:0] col;
  logic [2:0] page;
  logic col_remap;
  logic row_remap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_st <= ohpfs_pkg::C_IDLE;
      display_on <= 1'b0;
      contrast_a <= `OHPFS_CONTRAST_RST;
      contrast_b <= `OHPFS_CONTRAST_RST;
      contrast_c <= `OHPFS_CONTRAST_RST;
      col <= 7'h00;
      page <= 3'h0;
      col_remap <= 1'b0;
      row_remap <= 1'b0;
    end else if (clr) begin // R9
      cmd_st <= ohpfs_pkg::C_IDLE;
      display_on <= 1'b0;
      contrast_a <= `OHPFS_CONTRAST_RST;
      contrast_b <= `OHPFS_CONTRAST_RST;
      contrast_c <= `OHPFS_CONTRAST_RST;
      col <= 7'h00;
      page <= 3'h0;
      col_remap <= 1'b0;
      row_remap <= 1'b0;
    end else if (byte_stb && byte_dc) begin
      col <= col + 7'h01; // R22
    end else if (byte_stb) begin
      case (cmd_st)
        ohpfs_pkg::C_IDLE: begin
          if (byte_val == `OHPFS_CMD_OFF) display_on <= 1'b0; // R13
          else if (byte_val == `OHPFS_CMD_ON) display_on <= 1'b1; // R14
          else if (byte_val == `OHPFS_CMD_CONTRAST) cmd_st <= ohpfs_pkg::C_CA; // R15
          else if (byte_val == `OHPFS_CMD_REMAP) cmd_st <= ohpfs_pkg::C_REMAP;
          else if (cmd_hit(byte_val, `OHPFS_CMD_PAGE_MASK, `OHPFS_CMD_PAGE))
            page <= byte_val[2:0];
          else if (cmd_hit(byte_val, `OHPFS_CMD_COL_LO_MASK, `OHPFS_CMD_COL_LO))
            col[3:0] <= byte_val[3:0];
          else if (cmd_hit(byte_val, `OHPFS_CMD_COL_HI_MASK, `OHPFS_CMD_COL_HI))
            col[6:4] <= byte_val[2:0];
        end
        ohpfs_pkg::C_CA: begin
          contrast_a <= byte_val; // R15
          cmd_st <= ohpfs_pkg::C_CB;
        end
        ohpfs_pkg::C_CB: begin
          contrast_b <= byte_val; // R15
          cmd_st <= ohpfs_pkg::C_CC;
        end
        ohpfs_pkg::C_CC: begin
          contrast_c <= byte_val; // R15
          cmd_st <= ohpfs_pkg::C_IDLE;
        end
        ohpfs_pkg::C_REMAP: begin
          col_remap <= byte_val[`OHPFS_REMAP_COL_BIT]; // R20
          row_remap <= byte_val[`OHPFS_REMAP_ROW_BIT]; // R20
          cmd_st <= ohpfs_pkg::C_IDLE;
        end
        default: cmd_st <= ohpfs_pkg::C_IDLE;
      endcase
    end
  end

  // ***********************************
  // frame store
  // ***********************************
  // contents survive clear and sleep; no reset on the array keeps it a plain ram
  logic [7:0] frame_store [0:1023]; // R10

  always_ff @(posedge clk) begin
    if (byte_stb && byte_dc && !clr)
      frame_store[fs_index(page, col)] <= byte_val; // R11 R12
  end

  // ***********************************
  // panel drive and scan
  // ***********************************
  logic [31:0] on_cnt;
  wire logic [5:0] phys_row = row_remap ? ~scan_row : scan_row; // R20
  wire logic [6:0] phys_col = col_remap ? ~scan_col : scan_col; // R20

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= 32'h0;
      panel_drive_en <= 1'b0;
    end else if (clr || !display_on) begin
      on_cnt <= 32'h0;
      panel_drive_en <= 1'b0;
    end else if (!panel_drive_en) begin
      if (on_cnt == 32'(ON_DELAY_CYC - 1)) panel_drive_en <= 1'b1; // R18
      else on_cnt <= on_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pixel_out <= 1'b0;
    else pixel_out <= panel_drive_en
                      && frame_store[fs_index(phys_row[5:3], phys_col)][phys_row[2:0]]; // R12
  end

  // ***********************************
  // data pin drivers
  // ***********************************
  wire logic rd_act = par_on && !rd_n_q && wr_n_q; // R8
  wire logic [7:0] status = 8'({display_on, 6'h00}) << (`OHPFS_STAT_ON_BIT - 7 + 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe_n <= 8'hff;
    end else if (rd_act) begin
      data_oe_n <= 8'h00; // R5
      data_out <= dc_q ? frame_store[fs_index(page, col)] : status;
    end else if (i2c_ack && i2c_on) begin
      data_oe_n <= 8'hfb; // R3
      data_out <= 8'h00;
    end else begin
      data_oe_n <= 8'hff;
      data_out <= 8'h00;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_off;
    byte_stb && !byte_dc && cmd_st == ohpfs_pkg::C_IDLE && byte_val == 8'hae && !clr
      |=> !display_on ##1 !panel_drive_en;
  endproperty
  a_off: assert property (p_off) else $error("display off not taken"); // R13

  property p_on;
    byte_stb && !byte_dc && cmd_st == ohpfs_pkg::C_IDLE && byte_val == 8'haf && !clr
      |=> display_on;
  endproperty
  a_on: assert property (p_on) else $error("display on not taken"); // R14

  property p_drive;
    $rose(panel_drive_en) |-> display_on && $past(on_cnt) == 32'(ON_DELAY_CYC - 1);
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable timing wrong"); // R18

  property p_store;
    byte_stb && byte_dc && !clr |=> frame_store[fs_index($past(page), $past(col))]
      == $past(byte_val);
  endproperty
  a_store: assert property (p_store) else $error("column byte not stored"); // R11

  property p_advance;
    byte_stb && byte_dc && !clr |=> col == $past(col) + 7'h01 && page == $past(page);
  endproperty
  a_advance: assert property (p_advance) else $error("column did not advance"); // R22

  property p_cs;
    !cs_q |=> !byte_stb;
  endproperty
  a_cs: assert property (p_cs) else $error("byte taken while deselected"); // R7

  property p_contrast;
    byte_stb && !byte_dc && cmd_st == ohpfs_pkg::C_CC && !clr
      |=> contrast_c == $past(byte_val) && cmd_st == ohpfs_pkg::C_IDLE;
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast c wrong"); // R15

  property p_drive_bus;
    data_oe_n == 8'h00 |-> $past(rd_act) && mode == ohpfs_pkg::M_PAR;
  endproperty
  a_drive_bus: assert property (p_drive_bus) else $error("bus driven outside read"); // R5

  property p_clear;
    clr |=> !display_on && col == 7'h00 && page == 3'h0 && contrast_a == 8'h80;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restore"); // R9

  property p_mode;
    boot == 2'h2 && strap == 3'h6 |=> mode == ohpfs_pkg::M_PAR;
  endproperty
  a_mode: assert property (p_mode) else $error("parallel strap ignored"); // R1
endmodule
`default_nettype wire

// [verification/ohpfs_host.sv]
// host microcontroller model for the parallel and serial ports
`timescale 1ns/100ps
`default_nettype none
module ohpfs_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  output logic host_port_strap_0,
  output logic host_port_strap_1,
  output logic host_port_strap_2,
  output logic chip_select_n,
  output logic data_cmd_sel,
  output logic host_write_n,
  output logic host_read_n,
  output logic [7:0] data_in
);
  logic [7:0] host_d;
  logic sda_tied;
  // wire level: the device wins on every bit whose driver it enables
  wire logic [7:0] bus = (~data_oe_n & data_out) | (data_oe_n & host_d);
  // i2c: bits 2 and 1 tied together, open drain with a pull-up
  wire logic sda_w = bus[2] & bus[1];
  assign data_in = sda_tied ? {bus[7:3], sda_w, sda_w, bus[0]} : bus;
  initial begin
    {host_port_strap_2, host_port_strap_1, host_port_strap_0} = 3'h6;
    chip_select_n = 1'b1;
    data_cmd_sel = 1'b0;
    host_write_n = 1'b1;
    host_read_n = 1'b1;
    host_d = 8'h00;
    sda_tied = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic strap(input logic [2:0] s);
    @(posedge clk);
    {host_port_strap_2, host_port_strap_1, host_port_strap_0} <= s;
  endtask
  // data held 4 clocks before and 2 after the strobe rises
  task automatic wr(input logic cs_n, input logic dc, input logic [7:0] b);
    @(posedge clk);
    chip_select_n <= cs_n;
    data_cmd_sel <= dc;
    host_d <= b;
    host_write_n <= 1'b0;
    gap(4);
    host_write_n <= 1'b1;
    gap(2);
    host_d <= ~b;
    chip_select_n <= 1'b1;
    gap(6);
  endtask
  task automatic rd(input logic dc, output logic [7:0] b, output logic [7:0] oe);
    @(posedge clk);
    chip_select_n <= 1'b0;
    data_cmd_sel <= dc;
    host_read_n <= 1'b0;
    host_d <= ~host_d;
    gap(5);
    b = data_out;
    oe = data_oe_n;
    host_read_n <= 1'b1;
    gap(5);
    chip_select_n <= 1'b1;
    gap(2);
  endtask
  // clock rests low between bytes; unused pins tied low
  task automatic sb(input logic dc, input logic [7:0] b);
    @(posedge clk);
    chip_select_n <= 1'b0;
    data_cmd_sel <= dc;
    host_d <= 8'h00;
    for (int i = 7; i >= 0; i--) begin
      gap(3);
      host_d <= {6'h00, b[i], 1'b0};
      gap(3);
      host_d[0] <= 1'b1;
    end
    gap(4);
    host_d <= 8'h00;
    chip_select_n <= 1'b1;
    gap(3);
  endtask
  // six-clock scl phases: the ack needs four clocks to pass the input flops
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      host_d <= {5'h00, 1'b1, b[i], 1'b0};
      gap(6);
      host_d[0] <= 1'b1;
      gap(6);
    end
    host_d <= 8'h06;
    gap(6);
    host_d[0] <= 1'b1;
    gap(3);
    ack = data_in[1];
    gap(3);
  endtask
  task automatic i2c_frame(input logic [7:0] a, input logic [7:0] ctrl, input logic [7:0] b,
                           output logic [2:0] acks);
    @(posedge clk);
    sda_tied <= 1'b1;
    chip_select_n <= 1'b0;
    host_d <= 8'h07;
    gap(6);
    host_d[1] <= 1'b0;
    gap(6);
    i2c_byte(a, acks[2]);
    i2c_byte(ctrl, acks[1]);
    i2c_byte(b, acks[0]);
    host_d <= 8'h04;
    gap(6);
    host_d[0] <= 1'b1;
    gap(6);
    host_d[1] <= 1'b1;
    gap(6);
    chip_select_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the oled host port and frame store
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct {logic dc; logic [7:0] b; logic on; logic [7:0] a; logic [7:0] c;} ohpfs_row_s;
  logic clk, rst_n, module_clear_n, s0, s1, s2, cs_n, dc, wr_n, rd_n, on, drv, pix;
  logic [7:0] din, dout, oe_n, ca, cb, cc, rb, ro;
  logic [6:0] scan_col;
  logic [5:0] scan_row;
  int err_count, n_compared;
  logic [2:0] acks;
  // page 3, column 126, then wrap past the last column
  localparam logic [63:0] STORE_SEQ = 64'hb30e175ac3810000;
  localparam logic [31:0] SER_SEQ = 32'hc1112233;
  // data byte among the contrast values must not consume one
  ohpfs_row_s rows [8] = '{'{0, 8'haf, 1, 8'h80, 8'h80}, '{0, 8'hc1, 1, 8'h80, 8'h80},
    '{0, 8'ha2, 1, 8'ha2, 8'h80}, '{1, 8'h55, 1, 8'ha2, 8'h80}, '{0, 8'ha3, 1, 8'ha2, 8'h80},
    '{0, 8'h2f, 1, 8'ha2, 8'h2f}, '{0, 8'hae, 0, 8'ha2, 8'h2f}, '{0, 8'haf, 1, 8'ha2, 8'h2f}};
  ohpfs_host u_host (.clk(clk), .data_out(dout), .data_oe_n(oe_n), .host_port_strap_0(s0),
    .host_port_strap_1(s1), .host_port_strap_2(s2), .chip_select_n(cs_n), .data_cmd_sel(dc),
    .host_write_n(wr_n), .host_read_n(rd_n), .data_in(din));
  // short power-on delay keeps the run brief
  ohpfs_top #(.ON_DELAY_CYC(20)) u_dut (.clk(clk), .rst_n(rst_n),
    .module_clear_n(module_clear_n), .host_port_strap_0(s0), .host_port_strap_1(s1),
    .host_port_strap_2(s2), .chip_select_n(cs_n), .data_cmd_sel(dc), .host_write_n(wr_n),
    .host_read_n(rd_n), .data_in(din), .scan_col(scan_col), .scan_row(scan_row),
    .data_out(dout), .data_oe_n(oe_n), .display_on(on), .panel_drive_en(drv),
    .contrast_a(ca), .contrast_b(cb), .contrast_c(cc), .pixel_out(pix));
  always #50 clk = ~clk;
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // power-up wait cut to a few clocks to keep the run short
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_drive;
    int n;
    n = 0;
    while (drv !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk1(drv, 1'b1);
    if (drv !== 1'b1) close_out();
  endtask
  task automatic px(input logic [5:0] r, input logic [6:0] c, input logic e);
    @(posedge clk);
    scan_row <= r;
    scan_col <= c;
    repeat (3) @(posedge clk);
    chk1(pix, e);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    module_clear_n = 1'b1;
    scan_col = 7'h00;
    scan_row = 6'h00;
    err_count = 0;
    n_compared = 0;
    rst();
    chk1(on, 1'b0);
    chk8(ca, 8'h80);
    chk8(oe_n, 8'hff);
    $display("test reset done");
    foreach (rows[i]) begin
      u_host.wr(1'b0, rows[i].dc, rows[i].b);
      chk1(on, rows[i].on);
      chk8(ca, rows[i].a);
      chk8(cc, rows[i].c);
    end
    chk8(cb, 8'ha3);
    wait_drive();
    $display("test commands done");
    foreach (rows[i]) u_host.wr(1'b0, i >= 3, STORE_SEQ[8*(7-i) +: 8]);
    for (int k = 0; k < 8; k++) px(6'(24 + k), 7'h7e, STORE_SEQ[32 + k]);
    px(6'd24, 7'h00, 1'b1);
    px(6'd31, 7'h7f, 1'b1);
    u_host.wr(1'b0, 1'b0, 8'h0e);
    u_host.wr(1'b0, 1'b0, 8'h17);
    u_host.rd(1'b1, rb, ro);
    chk8(ro, 8'h00);
    chk8(rb, 8'h5a);
    u_host.rd(1'b1, rb, ro);
    chk8(rb, 8'h5a);
    u_host.rd(1'b0, rb, ro);
    chk8(rb, 8'h40);
    $display("test store done");
    u_host.wr(1'b0, 1'b0, 8'ha0);
    u_host.wr(1'b0, 1'b0, 8'h03);
    px(6'd38, 7'h01, 1'b1);
    px(6'd39, 7'h01, 1'b0);
    u_host.wr(1'b1, 1'b0, 8'hae);
    chk1(on, 1'b1);
    u_host.wr(1'b0, 1'b0, 8'hae);
    chk1(on, 1'b0);
    u_host.wr(1'b0, 1'b0, 8'haf);
    chk1(drv, 1'b0);
    wait_drive();
    px(6'd38, 7'h01, 1'b1);
    $display("test remap and sleep done");
    @(posedge clk);
    module_clear_n <= 1'b0;
    repeat (30) @(posedge clk);
    module_clear_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk1(on, 1'b0);
    chk8(ca, 8'h80);
    $display("test clear done");
    u_host.strap(3'h0);
    rst();
    u_host.sb(1'b0, 8'haf);
    chk1(on, 1'b1);
    for (int i = 0; i < 4; i++) u_host.sb(1'b0, SER_SEQ[8*(3-i) +: 8]);
    chk8(ca, 8'h11);
    chk8(cb, 8'h22);
    chk8(cc, 8'h33);
    $display("test serial done");
    u_host.strap(3'h2);
    rst();
    u_host.i2c_frame(8'h78, 8'h00, 8'haf, acks);
    chk8({5'h00, acks}, 8'h00);
    chk1(on, 1'b1);
    u_host.i2c_frame(8'h7a, 8'h00, 8'hae, acks);
    chk8({5'h00, acks}, 8'h07);
    chk1(on, 1'b1);
    u_host.i2c_frame(8'h78, 8'h40, 8'h0a, acks);
    chk8({5'h00, acks}, 8'h00);
    wait_drive();
    px(6'd0, 7'h00, 1'b0);
    px(6'd1, 7'h00, 1'b1);
    u_host.i2c_frame(8'h78, 8'h00, 8'hae, acks);
    chk1(on, 1'b0);
    $display("test i2c done");
    close_out();
  end
endmodule
`default_nettype wire
